// ==== mgp_host_model.sv ====
`timescale 1ns/1ps
// Host stand-in: arms turn off at once, on only after a dead time
module mgp_host_model #(
  parameter int unsigned DEAD = 20
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // Wanted pattern {w,v,u low, w,v,u high}
  input wire logic [5:0] want_i,
  // Commands to the block
  output logic [5:0] cmd_o
);
  logic [5:0] cnt_reg;
  // An off always resets the wait, so no arm rises inside 1 us of its partner falling
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cmd_o <= 6'h00;
      cnt_reg <= 6'h00;
    end else if ((cmd_o & ~want_i) != 6'h00) begin
      cmd_o <= cmd_o & want_i;
      cnt_reg <= 6'h00;
    end else if (cnt_reg < DEAD) begin
      cnt_reg <= cnt_reg + 6'h01;
    end else begin
      cmd_o <= want_i;
    end
  end
endmodule // mgp_host_model

// ==== mgp_phase.sv ====
`timescale 1ns/1ps
// One half-bridge: command gating and latched top-arm limit
module mgp_phase (
  // Clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // Commands
  input wire logic high_cmd_i,
  input wire logic low_cmd_i,
  // Protection
  input wire logic limit_hit_i,
  input wire logic all_off_i,
  // Switch drives
  output logic high_on_o,
  output logic low_on_o
);
  logic limit_reg;

  // Latch the limit; a new hit wins over the release when the high command drops
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      limit_reg <= 1'b0;
    end else if (limit_hit_i) begin
      limit_reg <= 1'b1;
    end else if (!high_cmd_i) begin
      limit_reg <= 1'b0;
    end
  end

  // Registered drives; both commands high means both off
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      high_on_o <= 1'b0;
      low_on_o <= 1'b0;
    end else begin
      high_on_o <= high_cmd_i && !low_cmd_i && !all_off_i && !limit_reg && !limit_hit_i;
      low_on_o <= low_cmd_i && !high_cmd_i && !all_off_i;
    end
  end
endmodule // mgp_phase

// ==== mgp_pkg.sv ====
package mgp_pkg;
  // Protection behaviour chosen by the strap
  typedef enum logic [1:0] {
    MGP_LIMIT_MANUAL,
    MGP_NOLIMIT_MANUAL,
    MGP_NOLIMIT_AUTO
  } mgp_mode_e;
  // Over-current latch states
  typedef enum logic [1:0] {
    MGP_RUN,
    MGP_TRIPPED
  } mgp_trip_e;
endpackage

// ==== mgp_regs.svh ====
`ifndef MGP_REGS_SVH
`define MGP_REGS_SVH

// Clock period in ns (20 MHz)
`define MGP_CLK_PERIOD_NS 50
// Manual clear time, typical and longest, in us
`define MGP_CLEAR_TYP_US 15
`define MGP_CLEAR_MAX_US 30
// Manual clear hold in cycles: equal to the typical figure, inside the longest one
`define MGP_CLEAR_CYCLES ((`MGP_CLEAR_TYP_US * 1000) / `MGP_CLK_PERIOD_NS)
// Automatic recovery time in us, stand-in for the external timing network
`define MGP_RECOVER_US 1000
`define MGP_RECOVER_CYCLES ((`MGP_RECOVER_US * 1000) / `MGP_CLK_PERIOD_NS)
// Strap encodings
`define MGP_STRAP_GROUND 2'h0
`define MGP_STRAP_7V5 2'h1
`define MGP_STRAP_SUPPLY 2'h2

`endif

// ==== mgp_top.sv ====
`timescale 1ns/1ps
`include "mgp_regs.svh"
module mgp_top #(
  parameter int unsigned RECOVER_CYCLES = `MGP_RECOVER_CYCLES,
  parameter int unsigned CLEAR_CYCLES = `MGP_CLEAR_CYCLES
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // Host commands
  input wire logic u_high_cmd_i,
  input wire logic v_high_cmd_i,
  input wire logic w_high_cmd_i,
  input wire logic u_low_cmd_i,
  input wire logic v_low_cmd_i,
  input wire logic w_low_cmd_i,
  // Comparator flags
  input wire logic limit_over_i,
  input wire logic trip_over_i,
  input wire logic undervolt_trip_i,
  input wire logic undervolt_release_i,
  input wire logic overheat_trip_i,
  input wire logic overheat_cooled_i,
  // Strap, sampled after reset release
  input wire logic [1:0] protect_strap_i,
  // Switch drives
  output logic u_high_on_o,
  output logic v_high_on_o,
  output logic w_high_on_o,
  output logic u_low_on_o,
  output logic v_low_on_o,
  output logic w_low_on_o,
  // Open-drain fault pin
  output logic fault_o,
  output logic fault_oe_o
);
  // Wide enough for any recovery count a user might set
  localparam int unsigned CNT_W = 32;

  // Protection state
  mgp_pkg::mgp_mode_e mode_reg;
  logic strap_taken_reg;
  mgp_pkg::mgp_trip_e trip_reg;
  logic [CNT_W-1:0] count_reg;
  logic uv_reg;
  logic ot_reg;
  // Decoded conditions
  logic all_off;
  logic limit_hit;
  logic cmds_low;
  logic auto_mode;
  logic manual_quiet;
  logic auto_done;
  logic manual_done;
  // Per-phase buses, index 0 is phase U
  logic [2:0] high_cmd;
  logic [2:0] low_cmd;
  logic [2:0] high_on;
  logic [2:0] low_on;

  // Strap caught once after release; outputs are held off until then
  // A strap change later on needs a reset to take effect
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mode_reg <= mgp_pkg::MGP_LIMIT_MANUAL;
      strap_taken_reg <= 1'b0;
    end else if (!strap_taken_reg) begin
      strap_taken_reg <= 1'b1;
      unique case (protect_strap_i)
        `MGP_STRAP_GROUND: mode_reg <= mgp_pkg::MGP_LIMIT_MANUAL;
        `MGP_STRAP_7V5: mode_reg <= mgp_pkg::MGP_NOLIMIT_MANUAL;
        default: mode_reg <= mgp_pkg::MGP_NOLIMIT_AUTO;
      endcase
    end
  end

  // Clear bookkeeping, decoded once so the latch and its counter agree
  assign cmds_low = !(|high_cmd) && !(|low_cmd);
  assign auto_mode = mode_reg == mgp_pkg::MGP_NOLIMIT_AUTO;
  // Host keeps all six low and the shunt is quiet; anything else restarts the wait
  assign manual_quiet = cmds_low && !trip_over_i;
  // Auto recovery ends on the last count; the latch clears on that edge
  assign auto_done = count_reg >= RECOVER_CYCLES - 1;
  // Manual clear needs the quiet spell to run one count past the clear time
  assign manual_done = count_reg >= CLEAR_CYCLES;

  // Over-current latch; a fresh trip always wins over either clear
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      trip_reg <= mgp_pkg::MGP_RUN;
    end else begin
      unique case (trip_reg)
        mgp_pkg::MGP_RUN: begin
          if (trip_over_i) begin
            trip_reg <= mgp_pkg::MGP_TRIPPED;
          end
        end
        mgp_pkg::MGP_TRIPPED: begin
          if (auto_mode) begin
            // Commands are ignored; only the running count or a still-high shunt holds the latch
            if (auto_done && !trip_over_i) begin
              trip_reg <= mgp_pkg::MGP_RUN;
            end
          end else if (manual_quiet && manual_done) begin
            trip_reg <= mgp_pkg::MGP_RUN;
          end
        end
        default: trip_reg <= mgp_pkg::MGP_TRIPPED;
      endcase
    end
  end

  // Shared timer: recovery time in automatic mode, quiet spell in manual modes
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      count_reg <= '0;
    end else if (trip_reg != mgp_pkg::MGP_TRIPPED) begin
      // Idle at zero so every trip starts a full wait
      count_reg <= '0;
    end else if (auto_mode) begin
      // Saturates at the end point rather than wrapping while the shunt stays high
      if (!auto_done) begin
        count_reg <= count_reg + 1'b1;
      end
    end else if (!manual_quiet) begin
      count_reg <= '0;
    end else if (!manual_done) begin
      count_reg <= count_reg + 1'b1;
    end
  end

  // Under-voltage with hysteresis: set on trip, cleared only above release
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      uv_reg <= 1'b1;
    end else if (undervolt_trip_i) begin
      uv_reg <= 1'b1;
    end else if (undervolt_release_i) begin
      uv_reg <= 1'b0;
    end
  end

  // Overheat with hysteresis: cleared only once cooled
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ot_reg <= 1'b0;
    end else if (overheat_trip_i) begin
      ot_reg <= 1'b1;
    end else if (overheat_cooled_i) begin
      ot_reg <= 1'b0;
    end
  end

  // Any global shutdown; raw flags also act at once to save a cycle
  // The latched flags carry the hysteresis; the raw ones only cover their first cycle
  assign all_off = !strap_taken_reg || uv_reg || undervolt_trip_i || ot_reg || overheat_trip_i
    || trip_reg == mgp_pkg::MGP_TRIPPED || trip_over_i;
  // Limit only in the ground-strap mode, and never before the strap is known
  assign limit_hit = limit_over_i && strap_taken_reg && mode_reg == mgp_pkg::MGP_LIMIT_MANUAL;

  // Pack the commands per phase
  assign high_cmd = {w_high_cmd_i, v_high_cmd_i, u_high_cmd_i};
  assign low_cmd = {w_low_cmd_i, v_low_cmd_i, u_low_cmd_i};

  // One half-bridge per phase
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_phase
      mgp_phase u_phase (
        .clock_i(clock_i),
        .arst_n_i(arst_n_i),
        .high_cmd_i(high_cmd[gi]),
        .low_cmd_i(low_cmd[gi]),
        .limit_hit_i(limit_hit),
        .all_off_i(all_off),
        .high_on_o(high_on[gi]),
        .low_on_o(low_on[gi])
      );
    end
  endgenerate

  // Unpack the drives; each bit leaves a phase flop directly
  assign {w_high_on_o, v_high_on_o, u_high_on_o} = high_on;
  assign {w_low_on_o, v_low_on_o, u_low_on_o} = low_on;

  // Fault pin pulled low only by an over-current trip, never by limit, UV or heat
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fault_oe_o <= 1'b0;
    end else begin
      fault_oe_o <= (trip_reg == mgp_pkg::MGP_TRIPPED) || trip_over_i;
    end
  end

  // Level while enabled; open drain only ever pulls low, the pull-up gives high
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fault_o <= 1'b0;
    end else begin
      fault_o <= 1'b0;
    end
  end
endmodule // mgp_top

// ==== mgp_top_chk.sv ====
`timescale 1ns/1ps
// Port-level checks of the gate and protection block
module mgp_top_chk (
  // Clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // Inputs watched
  input wire logic u_high_cmd_i,
  input wire logic u_low_cmd_i,
  input wire logic limit_over_i,
  input wire logic trip_over_i,
  input wire logic undervolt_trip_i,
  input wire logic undervolt_release_i,
  input wire logic overheat_trip_i,
  input wire logic [1:0] protect_strap_i,
  // Outputs watched
  input wire logic u_high_on_o,
  input wire logic v_high_on_o,
  input wire logic w_high_on_o,
  input wire logic u_low_on_o,
  input wire logic v_low_on_o,
  input wire logic w_low_on_o,
  input wire logic fault_o,
  input wire logic fault_oe_o
);
  default clocking dc @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  // Any arm on; shutdown checks only need the collapsed view
  wire tops = u_high_on_o | v_high_on_o | w_high_on_o;
  wire any_on = tops | u_low_on_o | v_low_on_o | w_low_on_o;
  a_both_cmd_off: assert property (u_high_cmd_i && u_low_cmd_i |=> !u_high_on_o && !u_low_on_o)
    else $error("phase pair not blocked");
  a_limit_top_off: assert property (limit_over_i && protect_strap_i == 2'h0 |=> !tops)
    else $error("limit left a top arm on");
  a_trip_all_off: assert property (trip_over_i |=> !any_on && fault_oe_o)
    else $error("trip not taken");
  a_fault_only_trip: assert property (!trip_over_i && !fault_oe_o |=> !fault_oe_o)
    else $error("fault without trip");
  a_pin_never_high: assert property (fault_o == 1'b0)
    else $error("fault pin driven high");
  a_uv_all_off: assert property (undervolt_trip_i |=> !any_on)
    else $error("undervolt left an arm on");
  a_uv_hold_off: assert property (undervolt_trip_i ##1 !undervolt_release_i |=> !any_on)
    else $error("undervolt released early");
  a_heat_all_off: assert property (overheat_trip_i |=> !any_on)
    else $error("overheat left an arm on");
  c_trip: cover property (trip_over_i ##1 fault_oe_o);
  c_clear: cover property ($fell(fault_oe_o));
  c_uv: cover property (undervolt_trip_i ##1 !undervolt_release_i);
endmodule // mgp_top_chk

bind mgp_top mgp_top_chk mgp_top_chk_i (
  .clock_i(clock_i),
  .arst_n_i(arst_n_i),
  .u_high_cmd_i(u_high_cmd_i),
  .u_low_cmd_i(u_low_cmd_i),
  .limit_over_i(limit_over_i),
  .trip_over_i(trip_over_i),
  .undervolt_trip_i(undervolt_trip_i),
  .undervolt_release_i(undervolt_release_i),
  .overheat_trip_i(overheat_trip_i),
  .protect_strap_i(protect_strap_i),
  .u_high_on_o(u_high_on_o),
  .v_high_on_o(v_high_on_o),
  .w_high_on_o(w_high_on_o),
  .u_low_on_o(u_low_on_o),
  .v_low_on_o(v_low_on_o),
  .w_low_on_o(w_low_on_o),
  .fault_o(fault_o),
  .fault_oe_o(fault_oe_o)
);

// ==== test_mgp_top.sv ====
`timescale 1ns/1ps
module test_mgp_top;
  logic clock_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [5:0] want = 6'h00;
  logic [5:0] cmd;
  logic [5:0] drv;
  logic fault_oe;
  logic fault_lvl;
  logic limit = 1'b0;
  logic trip = 1'b0;
  logic uv_trip = 1'b0;
  logic uv_rel = 1'b1;
  logic heat = 1'b0;
  logic cooled = 1'b1;
  logic [1:0] strap = 2'h0;
  wire pin = fault_oe ? fault_lvl : 1'b1; // Pull-up on the open-drain line
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;
  mgp_host_model mgp_host_model_i (.clock_i(clock_i), .arst_n_i(arst_n_i), .want_i(want), .cmd_o(cmd));
  mgp_top #(.RECOVER_CYCLES(20), .CLEAR_CYCLES(10)) mgp_top_i (.clock_i(clock_i), .arst_n_i(arst_n_i),
    .u_high_cmd_i(cmd[0]), .v_high_cmd_i(cmd[1]), .w_high_cmd_i(cmd[2]), .u_low_cmd_i(cmd[3]),
    .v_low_cmd_i(cmd[4]), .w_low_cmd_i(cmd[5]), .limit_over_i(limit), .trip_over_i(trip),
    .undervolt_trip_i(uv_trip), .undervolt_release_i(uv_rel), .overheat_trip_i(heat),
    .overheat_cooled_i(cooled), .protect_strap_i(strap), .u_high_on_o(drv[0]), .v_high_on_o(drv[1]),
    .w_high_on_o(drv[2]), .u_low_on_o(drv[3]), .v_low_on_o(drv[4]), .w_low_on_o(drv[5]),
    .fault_o(fault_lvl), .fault_oe_o(fault_oe));
  // Clock and hang guard
  initial begin
    forever #25 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 4000) begin
      mismatches++;
      end_sim();
    end
  end
  task end_sim;
    if (mismatches == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Judged at the falling edge, clear of the update edge
  task chk(input logic [6:0] exp);
    @(negedge clock_i);
    total_checks++;
    if ({pin, drv} !== exp) begin
      mismatches++;
      $display("unexpected %0t got %h", $time, {pin, drv});
    end
  endtask
  task go(input logic [5:0] w, input int n);
    @(posedge clock_i) want <= w;
    repeat (n) @(posedge clock_i);
  endtask
  // Strap is only taken after reset, so each mode needs a fresh reset
  task start(input logic [1:0] s);
    @(posedge clock_i) arst_n_i <= 1'b0;
    strap <= s;
    want <= 6'h00;
    repeat (5) @(posedge clock_i);
    arst_n_i <= 1'b1;
  endtask
  task pulse_trip;
    @(posedge clock_i) trip <= 1'b1;
    @(posedge clock_i) trip <= 1'b0;
  endtask
  task t_gates;
    start(2'h1);
    for (int p = 0; p < 3; p++) begin
      go(6'h01 << p, 30);
      chk({1'b1, 6'h01 << p});
      go(6'h08 << p, 30);
      chk({1'b1, 6'h08 << p});
      go(6'h09 << p, 30);
      chk(7'h40);
    end
    go(6'h07, 30);
    @(posedge clock_i) limit <= 1'b1;
    @(posedge clock_i) limit <= 1'b0;
    repeat (3) @(posedge clock_i);
    chk(7'h47);
  endtask
  task t_limit;
    start(2'h0);
    go(6'h07, 30);
    @(posedge clock_i) limit <= 1'b1;
    @(posedge clock_i) limit <= 1'b0;
    repeat (3) @(posedge clock_i);
    chk(7'h40);
    go(6'h06, 30);
    go(6'h07, 30);
    chk(7'h41);
  endtask
  task t_manual;
    start(2'h1);
    go(6'h21, 30);
    pulse_trip();
    chk(7'h00);
    go(6'h01, 20);
    chk(7'h00);
    go(6'h00, 11);
    chk(7'h00);
    repeat (2) @(posedge clock_i);
    chk(7'h40);
  endtask
  // Main-supply strap, both codes: released exactly at the end of the recovery count
  task t_auto(input logic [1:0] s);
    start(s);
    go(6'h01, 30);
    pulse_trip();
    repeat (20) @(posedge clock_i);
    chk(7'h00);
    @(posedge clock_i);
    chk(7'h41);
  endtask
  // Undervolt first, then overheat, each held off until its release flag
  task t_shutdown;
    start(2'h1);
    go(6'h02, 30);
    for (int k = 0; k < 2; k++) begin
      @(posedge clock_i) uv_trip <= k == 0;
      uv_rel <= k != 0;
      heat <= k == 1;
      cooled <= k == 0;
      @(posedge clock_i) uv_trip <= 1'b0;
      heat <= 1'b0;
      repeat (10) @(posedge clock_i);
      chk(7'h40);
      @(posedge clock_i) uv_rel <= 1'b1;
      cooled <= 1'b1;
      repeat (3) @(posedge clock_i);
      chk(7'h42);
    end
  endtask
  initial begin
    t_gates();
    t_limit();
    t_manual();
    t_auto(2'h2);
    t_auto(2'h3);
    t_shutdown();
    end_sim();
  end
endmodule // test_mgp_top
